// ### logic/udc_pkg.sv
// package: widths, count limits and reset values for the up/down counter
package udc_pkg;
    localparam int UDC_WIDTH = 4; // width of the count
    localparam logic [3:0] UDC_ZERO = 4'h0; // cleared count value
    localparam logic [3:0] UDC_MAX = 4'hF; // top of the count range
    localparam logic [3:0] UDC_STEP = 4'h1; // increment / decrement step
    localparam logic [1:0] UDC_SYNC_INIT = 2'h3; // up, down and preset sync chains idle high; clear chain idles low
    // direction selected for the current cycle
    typedef enum logic [1:0] {
        UDC_HOLD,
        UDC_UP,
        UDC_DOWN
    } udc_dir_t;
endpackage

// ### logic/udc_step_if.sv
// interface: count state and step request between the counter and its core
`timescale 1ns/1ns
`default_nettype none
interface udc_step_if;
    import udc_pkg::*;
    logic [UDC_WIDTH-1:0] count; // present count
    udc_dir_t dir; // requested step direction
    logic [UDC_WIDTH-1:0] next_count; // stepped value
    modport ctrl (output count, output dir, input next_count);
    modport core (input count, input dir, output next_count);
endinterface
`default_nettype wire

// ### logic/udc_step_core.sv
// module: stepping arithmetic with wrap for the up/down counter
`timescale 1ns/1ns
`default_nettype none
module udc_step_core
    import udc_pkg::*;
(
    udc_step_if.core step_io // count in, stepped count out
);
    // -----------------------------------------------------------------
    // step arithmetic
    // -----------------------------------------------------------------
    // modulo-16 arithmetic: fifteen plus one wraps to zero
    wire [UDC_WIDTH-1:0] inc_value = step_io.count + UDC_STEP;
    // zero minus one wraps to fifteen
    wire [UDC_WIDTH-1:0] dec_value = step_io.count - UDC_STEP;

    // select by direction; hold keeps the count
    assign step_io.next_count = (step_io.dir == UDC_UP) ? inc_value :
                                (step_io.dir == UDC_DOWN) ? dec_value :
                                step_io.count;
endmodule
`default_nettype wire

// ### logic/udc_counter.sv
// module: dual-clock 4-bit up/down counter with preset and clear
`timescale 1ns/1ns
`default_nettype none
module udc_counter
    import udc_pkg::*;
(
    input wire logic clk_in, // 50 MHz system clock
    input wire logic sys_rst_in, // async reset, active high
    input wire logic count_up_in, // count-up clock pin
    input wire logic count_down_in, // count-down clock pin
    input wire logic preset_n_in, // preset control, active low
    input wire logic async_clear, // clear pin, active high
    input wire logic [3:0] data_in, // preset data
    output logic count_bit0_out, // count bit 0
    output logic count_bit1_out, // count bit 1
    output logic count_bit2_out, // count bit 2
    output logic count_bit3_out, // count bit 3
    output logic borrow_out_n, // borrow, active low
    output logic carry_out_n // carry, active low
);
    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    logic [1:0] up_sync; // up clock chain
    logic [1:0] down_sync; // down clock chain
    logic [1:0] preset_sync; // preset chain
    logic [1:0] clear_sync; // clear chain
    logic [3:0] data_meta; // data first stage
    logic [3:0] data_sync; // data second stage
    logic up_prev; // up level one cycle back
    logic down_prev; // down level one cycle back

    // two flops on every pin; only stage [1] is read by logic
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            up_sync <= UDC_SYNC_INIT;
            down_sync <= UDC_SYNC_INIT;
            preset_sync <= UDC_SYNC_INIT;
            clear_sync <= 2'h0;
            data_meta <= UDC_ZERO;
            data_sync <= UDC_ZERO;
        end else begin
            up_sync <= {up_sync[0], count_up_in};
            down_sync <= {down_sync[0], count_down_in};
            preset_sync <= {preset_sync[0], preset_n_in};
            clear_sync <= {clear_sync[0], async_clear};
            data_meta <= data_in;
            data_sync <= data_meta;
        end
    end

    // edge history taken from the synchronised levels
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            up_prev <= 1'b1;
            down_prev <= 1'b1;
        end else begin
            up_prev <= up_sync[1];
            down_prev <= down_sync[1];
        end
    end

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    wire up_level = up_sync[1]; // synchronised up clock
    wire down_level = down_sync[1]; // synchronised down clock
    wire clear_act = clear_sync[1]; // clear asserted
    wire preset_act = ~preset_sync[1]; // preset asserted
    // rising edges of the count clocks
    wire up_rise = up_level & ~up_prev;
    wire down_rise = down_level & ~down_prev;
    // a step counts only while the other clock stands high
    wire up_step = up_rise & down_level;
    wire down_step = down_rise & up_level;

    // -----------------------------------------------------------------
    // count state
    // -----------------------------------------------------------------
    logic [UDC_WIDTH-1:0] count;
    logic [UDC_WIDTH-1:0] next_count; // next count value
    udc_step_if step_bus (); // link to the step core
    udc_dir_t step_dir; // direction for this cycle

    assign step_dir = up_step ? UDC_UP :
                      down_step ? UDC_DOWN : UDC_HOLD;
    assign step_bus.count = count;
    assign step_bus.dir = step_dir;

    // stepping arithmetic with wrap at both ends
    udc_step_core u_step (
        .step_io(step_bus.core)
    );

    // clear first, then preset, then a count step
    assign next_count = clear_act ? UDC_ZERO :
                        preset_act ? data_sync :
                        step_bus.next_count;

    // whole word loads at once: no ripple between bits
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count <= UDC_ZERO;
        end else begin
            count <= next_count;
        end
    end

    // -----------------------------------------------------------------
    // cascade outputs
    // -----------------------------------------------------------------
    // next-state forms so the registered pins track count and clocks;
    // only the second sync stage is read, never the metastable first one
    wire next_borrow_n = ~((next_count == UDC_ZERO) & ~down_level);
    wire next_carry_n = ~((next_count == UDC_MAX) & ~up_level);

    // outputs registered; drive the next stage's clocks (cascade)
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_bit0_out <= 1'b0;
            count_bit1_out <= 1'b0;
            count_bit2_out <= 1'b0;
            count_bit3_out <= 1'b0;
            borrow_out_n <= 1'b1;
            carry_out_n <= 1'b1;
        end else begin
            count_bit0_out <= next_count[0];
            count_bit1_out <= next_count[1];
            count_bit2_out <= next_count[2];
            count_bit3_out <= next_count[3];
            borrow_out_n <= next_borrow_n;
            carry_out_n <= next_carry_n;
        end
    end
endmodule
`default_nettype wire

// ### verif/udc_driver.sv
// far-side model: logic that drives the counter's pins
`timescale 1ns/1ns
`default_nettype none
module udc_driver (
    input wire logic clk_in, // system clock
    output logic up_out, // count-up clock pin
    output logic down_out, // count-down clock pin
    output logic preset_n_out, // preset, active low
    output logic clear_out, // clear, active high
    output logic [3:0] data_out // preset data
);
    // idle: both count pins high, preset off, clear off
    initial {up_out, down_out, preset_n_out, clear_out, data_out} = 8'hE0;
    // move one count pin; the other pin stays high meanwhile
    task automatic pin(input logic up, input logic lvl);
        if (up) begin
            up_out = lvl;
        end else begin
            down_out = lvl;
        end
        repeat (4) @(negedge clk_in);
    endtask
    // set preset, clear and data levels, then let them stand
    task automatic ctl(input logic pn, input logic cl, input logic [3:0] d);
        {preset_n_out, clear_out, data_out} = {pn, cl, d};
        repeat (4) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// ### verif/udc_counter_asserts.sv
// checker: timing relations at the counter's ports
`timescale 1ns/1ns
`default_nettype none
module udc_counter_asserts (
    input wire logic clk_in, // clock
    input wire logic sys_rst_in, // reset
    input wire logic count_up_in, // up pin
    input wire logic count_down_in, // down pin
    input wire logic preset_n_in, // preset
    input wire logic async_clear, // clear
    input wire logic [3:0] data_in, // data
    input wire logic count_bit0_out, // bit 0
    input wire logic count_bit1_out, // bit 1
    input wire logic count_bit2_out, // bit 2
    input wire logic count_bit3_out, // bit 3
    input wire logic borrow_out_n, // borrow
    input wire logic carry_out_n // carry
);
    wire [3:0] cnt = {count_bit3_out, count_bit2_out, count_bit1_out,
        count_bit0_out}; // gathered count
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    up_step_a: assert property ($rose(count_up_in) && count_down_in &&
        preset_n_in && !async_clear |-> ##3 cnt == $past(cnt, 3) + 4'h1)
        else $error("up step wrong");
    down_step_a: assert property ($rose(count_down_in) && count_up_in &&
        preset_n_in && !async_clear |-> ##3 cnt == $past(cnt, 3) - 4'h1)
        else $error("down step wrong");
    clear_zero_a: assert property (async_clear[*4] |=> cnt == 4'h0)
        else $error("clear did not zero");
    preset_load_a: assert property ((!preset_n_in && !async_clear &&
        $stable(data_in))[*5] |-> cnt == data_in) else $error("no preset");
    idle_hold_a: assert property ((count_up_in && count_down_in &&
        preset_n_in && !async_clear)[*5] |-> $stable(cnt))
        else $error("count moved while idle");
    borrow_low_a: assert property ((cnt == 4'h0 && !count_down_in)[*4]
        |-> !borrow_out_n) else $error("borrow missing");
    borrow_high_a: assert property ((count_down_in || cnt != 4'h0)[*4]
        |-> borrow_out_n) else $error("borrow spurious");
    carry_low_a: assert property ((cnt == 4'hF && !count_up_in)[*4]
        |-> !carry_out_n) else $error("carry missing");
    carry_high_a: assert property ((count_up_in || cnt != 4'hF)[*4]
        |-> carry_out_n) else $error("carry spurious");
    cover property (!carry_out_n);
    cover property (!borrow_out_n);
    cover property (async_clear && !preset_n_in);
endmodule
bind udc_counter udc_counter_asserts udc_counter_asserts_i (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .count_up_in(count_up_in),
    .count_down_in(count_down_in), .preset_n_in(preset_n_in),
    .async_clear(async_clear), .data_in(data_in), .count_bit0_out(
    count_bit0_out), .count_bit1_out(count_bit1_out), .count_bit2_out(
    count_bit2_out), .count_bit3_out(count_bit3_out),
    .borrow_out_n(borrow_out_n), .carry_out_n(carry_out_n));
`default_nettype wire

// ### verif/udc_counter_tb_top.sv
// testbench for the dual-clock up/down counter
`timescale 1ns/1ns
`default_nettype none
module udc_counter_tb_top;
    logic clk_in = 1'b0; // system clock
    logic sys_rst_in = 1'b1; // reset, held at start
    wire up, down, pre_n, clr, bo_n, co_n; // pins
    wire [3:0] data, cnt; // preset data and count
    int failures = 0;
    int tests_run = 0;
    logic [3:0] e; // expected count
    always #10 clk_in = ~clk_in;
    udc_driver udc_driver_i (.clk_in(clk_in), .up_out(up), .down_out(down),
        .preset_n_out(pre_n), .clear_out(clr), .data_out(data));
    udc_counter udc_counter_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .count_up_in(up), .count_down_in(down), .preset_n_in(pre_n),
        .async_clear(clr), .data_in(data), .count_bit0_out(cnt[0]),
        .count_bit1_out(cnt[1]), .count_bit2_out(cnt[2]),
        .count_bit3_out(cnt[3]), .borrow_out_n(bo_n), .carry_out_n(co_n));
    // compare and count
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // clear wins over preset and a down pulse
    task automatic t_clear();
        udc_driver_i.ctl(1'b0, 1'b1, 4'h5);
        chk(cnt, 4'h0);
        udc_driver_i.pin(1'b0, 1'b0);
        chk({3'h0, bo_n}, 4'h0);
        udc_driver_i.pin(1'b0, 1'b1);
        chk(cnt, 4'h0);
        $display("clear test done");
    endtask
    // preset loads, an up pulse ignored meanwhile
    task automatic t_preset();
        udc_driver_i.ctl(1'b0, 1'b0, 4'hD);
        chk(cnt, 4'hD);
        udc_driver_i.pin(1'b1, 1'b0);
        udc_driver_i.pin(1'b1, 1'b1);
        chk(cnt, 4'hD);
        udc_driver_i.ctl(1'b1, 1'b0, 4'hD);
        $display("preset test done");
    endtask
    // count up through the wrap, then back down through it
    task automatic t_count(input logic up);
        repeat (5) begin
            udc_driver_i.pin(up, 1'b0);
            chk({3'h0, up ? co_n : bo_n},
                {3'h0, e != (up ? 4'hF : 4'h0)});
            udc_driver_i.pin(up, 1'b1);
            e = up ? e + 4'h1 : e - 4'h1;
            chk(cnt, e);
        end
        $display("count test done");
    endtask
    initial begin
        repeat (3) @(negedge clk_in);
        sys_rst_in = 1'b0;
        t_clear();
        t_preset();
        e = 4'hD;
        t_count(1'b1);
        t_count(1'b0);
        close_out();
    end
    // watchdog
    initial begin
        #20000;
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
